// ===== mac_statistics_counters.sv
// Operation
// - Count collisions at or past 512 bit times.
// - Count pause frames sent.
// - Count good broadcasts sent, including those also flagged multicast.
// - Count good multicasts sent, excluding broadcast.
// - Count good unicast frames sent.
// - Count frames deferred on first attempt.
// - Count collisions, only in half duplex.
// - Count frames abandoned after excessive collisions.
// - Count frames sent after exactly one collision.
// - Count frames sent after several collisions.
// - Control write selects offset, starts fetch.
// - High half then low half presented.
// - Bit 31 flags counter overflow.
// - Bit 30 low means fetch not done.
// - Reading a counter clears it.
// - 30-bit count, valid, overflow; reset zero.
// - 32 counters at offsets 0x00 to 0x1F.
module mac_statistics_counters (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Register port
  input wire logic [stats_pkg::ADDR_W-1:0] regAddr,
  input wire logic [stats_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [stats_pkg::DATA_W-1:0] regRdData,
  // Transmit status
  input wire logic txDone,
  input wire logic txGood,
  input wire logic txBroadcast,
  input wire logic txMulticast,
  input wire logic txPause,
  input wire logic deferred_send_count,
  input wire logic txExcessive,
  input wire logic [stats_pkg::COLL_W-1:0] txCollNum,
  input wire logic txCollision,
  input wire logic [stats_pkg::BIT_W-1:0] collBitTime,
  input wire logic halfDuplex,
  // Receive side events
  input wire logic [stats_pkg::RX_NUM-1:0] rxEvent,
  // Interrupt
  output logic irq
);
  import stats_pkg::*;

  // Transmit increment pulses from the decoder.
  logic [TX_NUM-1:0] txInc;
  // Increment, clear and wrap per counter.
  logic [NUM_CNT-1:0] incVec;
  logic [NUM_CNT-1:0] clrVec;
  logic [NUM_CNT-1:0] wrapVec;
  logic [NUM_CNT-1:0] ovfVec;
  // Count of every counter, addressed by offset.
  logic [CNT_W-1:0] cntArr [NUM_CNT];

  // Fetch sequencer state and selected offset.
  fetch_state_t state_q, state_d;
  logic [IDX_W-1:0] ofs_q, ofs_d;
  // Returned counter word, seen as two halves.
  logic [2*DATA_W-1:0] word_q, word_d;
  // Last written control value, trigger bit not kept.
  logic [DATA_W-1:0] ctrl_q, ctrl_d;
  // Interrupt status and mask.
  logic [IRQ_W-1:0] stat_q, stat_d;
  logic [IRQ_W-1:0] mask_q, mask_d;
  // Read data, valid only the cycle after a read.
  logic [DATA_W-1:0] rd_q, rd_d;

  // Decoded write strobes.
  logic wrCtrl;
  logic wrStat;
  logic wrMask;
  // A fetch request on this cycle.
  logic trig;
  // A fetch completes on this cycle.
  logic loadNow;
  // Hardware events for the interrupt status.
  logic [IRQ_W-1:0] irqEv;

  // The decoder only combines status lines; it holds no state.
  tx_event_decode u_dec (
    .clk(clk),
    .rst_n(rst_n),
    .txDone(txDone),
    .txGood(txGood),
    .txBroadcast(txBroadcast),
    .txMulticast(txMulticast),
    .txPause(txPause),
    .deferred_send_count(deferred_send_count),
    .txExcessive(txExcessive),
    .txCollNum(txCollNum),
    .txCollision(txCollision),
    .collBitTime(collBitTime),
    .halfDuplex(halfDuplex),
    .txInc(txInc)
  );

  // Receive events fill the low offsets and transmit events the top ten.
  // Reserved offsets never count, so they always read back as zero.
  always_comb begin
    incVec = {txInc, rxEvent} & ~RSVD_MASK;
  end

  // One counter per offset; the array is what the fetch indexes.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
      stat_counter u_cnt (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .incEn(incVec[gi]),
        .clrEn(clrVec[gi]),
        .count(cntArr[gi]),
        .overflow(ovfVec[gi]),
        .wrapPulse(wrapVec[gi])
      );
    end
  endgenerate

  // Write decode and fetch trigger recognition.
  // Offsets above the counter range are refused so no stray clear happens.
  always_comb begin
    wrCtrl = regWr && (regAddr == REG_CTRL);
    wrStat = regWr && (regAddr == REG_IRQ_STAT);
    wrMask = regWr && (regAddr == REG_IRQ_MASK);
    trig = wrCtrl && regWrData[CTRL_TRIG_BIT] &&
      (regWrData[CTRL_SEL_LSB +: 2] == SEL_STATS) &&
      (regWrData[CTRL_OFS_HI:IDX_W] == '0);
  end

  // Fetch sequencer: a trigger waits one cycle, then loads and clears.
  // A new trigger always restarts; the old counter is then left intact.
  always_comb begin
    state_d = state_q;
    ofs_d = ofs_q;
    word_d = word_q;
    loadNow = 1'b0;
    clrVec = '0;
    case (state_q)
      FS_IDLE: begin
        state_d = FS_IDLE;
      end
      FS_WAIT: begin
        state_d = FS_LOAD;
      end
      FS_LOAD: begin
        loadNow = 1'b1;
        state_d = FS_IDLE;
        word_d[WORD_OVF_BIT] = ovfVec[ofs_q];
        word_d[WORD_VALID_BIT] = 1'b1;
        word_d[CNT_W-1:0] = cntArr[ofs_q];
        clrVec[ofs_q] = 1'b1;
      end
      default: begin
        state_d = FS_IDLE;
      end
    endcase
    if (trig) begin
      // The word reads not valid until the new fetch lands.
      state_d = FS_WAIT;
      ofs_d = regWrData[IDX_W-1:0];
      word_d = '0;
      loadNow = 1'b0;
      clrVec = '0;
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= FS_IDLE;
      ofs_q <= '0;
      word_q <= '0;
    end else if (clkEn) begin
      state_q <= state_d;
      ofs_q <= ofs_d;
      word_q <= word_d;
    end
  end

  // Control, interrupt status and mask next values.
  // Status is write-one-to-clear, and a new event beats the clear.
  always_comb begin
    irqEv = '0;
    irqEv[IRQ_FETCH] = loadNow;
    irqEv[IRQ_OVF] = |wrapVec;
    ctrl_d = ctrl_q;
    if (wrCtrl) begin
      ctrl_d = regWrData;
      ctrl_d[CTRL_TRIG_BIT] = 1'b0;
    end
    stat_d = stat_q;
    if (wrStat) begin
      stat_d = stat_q & ~regWrData[IRQ_W-1:0];
    end
    stat_d = stat_d | irqEv;
    mask_d = wrMask ? regWrData[IRQ_W-1:0] : mask_q;
  end

  // Read mux; data lines are zero except in the cycle after a read.
  // Unmapped offsets read as zero.
  always_comb begin
    rd_d = '0;
    if (regRd) begin
      case (regAddr)
        REG_CTRL: begin
          rd_d = ctrl_q;
        end
        REG_DATA_HI: begin
          rd_d = word_q[2*DATA_W-1:DATA_W];
        end
        REG_DATA_LO: begin
          rd_d = word_q[DATA_W-1:0];
        end
        REG_IRQ_STAT: begin
          rd_d[IRQ_W-1:0] = stat_q;
        end
        REG_IRQ_MASK: begin
          rd_d[IRQ_W-1:0] = mask_q;
        end
        default: begin
          rd_d = '0;
        end
      endcase
    end
  end

  // Register file flip-flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0;
      stat_q <= '0;
      mask_q <= '0;
      rd_q <= '0;
    end else if (clkEn) begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rd_q <= rd_d;
    end
  end

  // Outputs.
  assign regRdData = rd_q;
  // Level interrupt while any unmasked status bit is set.
  assign irq = |(stat_q & mask_q);

  // Helper: the counter value seen at the load.
  logic [CNT_W-1:0] selCnt;
  assign selCnt = cntArr[ofs_q];

  property p_trig_invalid;
    @(posedge clk) disable iff (!rst_n)
    clkEn && trig |=> !word_q[WORD_VALID_BIT] && state_q == FS_WAIT;
  endproperty
  a_trig_invalid: assert property (p_trig_invalid) else $error("stale word valid");

  property p_fetch_two;
    @(posedge clk) disable iff (!rst_n)
    clkEn && trig ##1 (clkEn && !trig)[*2] |=> word_q[WORD_VALID_BIT];
  endproperty
  a_fetch_two: assert property (p_fetch_two) else $error("fetch not done in two");

  property p_load_word;
    @(posedge clk) disable iff (!rst_n)
    clkEn && state_q == FS_LOAD && !trig |=>
      word_q[CNT_W-1:0] == $past(selCnt) && word_q[WORD_OVF_BIT] == $past(ovfVec[ofs_q]);
  endproperty
  a_load_word: assert property (p_load_word) else $error("word mismatch");

  property p_load_clear;
    @(posedge clk) disable iff (!rst_n)
    clkEn && state_q == FS_LOAD && !trig && !incVec[ofs_q] |=> cntArr[$past(ofs_q)] == '0;
  endproperty
  a_load_clear: assert property (p_load_clear) else $error("read did not clear");

  property p_read_hi;
    @(posedge clk) disable iff (!rst_n)
    clkEn && regRd && regAddr == REG_DATA_HI |=> regRdData == $past(word_q[2*DATA_W-1:DATA_W]);
  endproperty
  a_read_hi: assert property (p_read_hi) else $error("high half wrong");

  property p_rsvd;
    @(posedge clk) disable iff (!rst_n)
    (incVec & RSVD_MASK) == '0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved offset counts");

  property p_irq_fetch;
    @(posedge clk) disable iff (!rst_n)
    clkEn && loadNow && mask_q[IRQ_FETCH] && !wrMask |=> irq;
  endproperty
  a_irq_fetch: assert property (p_irq_fetch) else $error("fetch interrupt lost");

  // The read data lines rest at zero outside the cycle after a read.
  property p_rd_idle;
    @(posedge clk) disable iff (!rst_n)
    clkEn && !regRd |=> regRdData == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

  // The low half follows the same one-cycle timing as the high half.
  property p_read_lo;
    @(posedge clk) disable iff (!rst_n)
    clkEn && regRd && regAddr == REG_DATA_LO |=> regRdData == $past(word_q[DATA_W-1:0]);
  endproperty
  a_read_lo: assert property (p_read_lo) else $error("low half wrong");

  // A refused trigger must leave an idle sequencer idle, so no counter is cleared.
  property p_refuse;
    @(posedge clk) disable iff (!rst_n)
    clkEn && wrCtrl && !trig && state_q == FS_IDLE |=> state_q == FS_IDLE;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused trigger fetched");

  // A set status bit stays until software writes a one to it.
  property p_stat_sticky;
    @(posedge clk) disable iff (!rst_n)
    clkEn && stat_q[IRQ_FETCH] && !(wrStat && regWrData[IRQ_FETCH]) |=> stat_q[IRQ_FETCH];
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost");

  // With the enable low nothing moves, not even a fetch in flight.
  property p_freeze;
    @(posedge clk) disable iff (!rst_n)
    !clkEn |=> $stable(state_q) && $stable(word_q) && $stable(stat_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  c_fetch: cover property (@(posedge clk) disable iff (!rst_n)
    clkEn && trig ##1 clkEn[*2] ##1 word_q[WORD_VALID_BIT]);
  c_wrap: cover property (@(posedge clk) disable iff (!rst_n) |wrapVec);
  c_retrig: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == FS_WAIT && trig);
  c_irq: cover property (@(posedge clk) disable iff (!rst_n) irq);
  c_frozen: cover property (@(posedge clk) disable iff (!rst_n) !clkEn && |incVec);
endmodule

// ===== stats_pkg.sv
// Shared widths, register map, field layout and states of the counter bank.
package stats_pkg;
  // Register port widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // Counter geometry: 32 counters of a 30-bit count each.
  localparam int CNT_W = 30;
  localparam int NUM_CNT = 32;
  localparam int IDX_W = 5;
  localparam int RX_NUM = 22;
  localparam int TX_NUM = 10;
  localparam int COLL_W = 5;
  localparam int BIT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ONE = 30'h1;
  localparam logic [CNT_W-1:0] CNT_MAX = 30'h3fffffff;
  // Offsets that hold no counter.
  localparam logic [NUM_CNT-1:0] RSVD_MASK = 32'h00200002;
  // Register offsets on the plain register port.
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_DATA_HI = 8'h02;
  localparam logic [ADDR_W-1:0] REG_DATA_LO = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h06;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h08;
  // Indirect access control fields: trigger, table select, offset.
  localparam int CTRL_TRIG_BIT = 12;
  localparam int CTRL_SEL_LSB = 10;
  localparam logic [1:0] SEL_STATS = 2'h3;
  localparam int CTRL_OFS_HI = 7;
  // Returned word flags.
  localparam int WORD_OVF_BIT = 31;
  localparam int WORD_VALID_BIT = 30;
  // Collision at or later than this bit time counts as late.
  localparam logic [BIT_W-1:0] LATE_BIT_TIME = 16'h0200;
  // Transmit counter positions relative to the first transmit offset.
  localparam int TX_BASE = 22;
  localparam int TXI_LATE = 0;
  localparam int TXI_PAUSE = 1;
  localparam int TXI_BCAST = 2;
  localparam int TXI_MCAST = 3;
  localparam int TXI_UCAST = 4;
  localparam int TXI_DEFER = 5;
  localparam int TXI_TOTAL = 6;
  localparam int TXI_ABORT = 7;
  localparam int TXI_ONE = 8;
  localparam int TXI_MANY = 9;
  localparam logic [COLL_W-1:0] COLL_ONE = 5'h01;
  // Interrupt status bits.
  localparam int IRQ_W = 2;
  localparam int IRQ_FETCH = 0;
  localparam int IRQ_OVF = 1;
  // Fetch sequencer states.
  typedef enum logic [2:0] {
    FS_IDLE = 3'h1,
    FS_WAIT = 3'h2,
    FS_LOAD = 3'h4
  } fetch_state_t;
endpackage

// ===== stat_counter.sv
// One read-clear statistics counter with a sticky overflow flag.
module stat_counter (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Control
  input wire logic incEn,
  input wire logic clrEn,
  // State
  output logic [stats_pkg::CNT_W-1:0] count,
  output logic overflow,
  output logic wrapPulse
);
  import stats_pkg::*;
  logic [CNT_W-1:0] cnt_q, cnt_d; // Count value.
  logic ovf_q, ovf_d; // Sticky overflow.

  // An event in the clearing cycle survives as a count of one.
  always_comb begin
    cnt_d = cnt_q;
    ovf_d = ovf_q;
    wrapPulse = 1'b0;
    if (clrEn) begin
      cnt_d = '0;
      ovf_d = 1'b0;
    end
    if (incEn) begin
      cnt_d = clrEn ? CNT_ONE : cnt_q + CNT_ONE;
      wrapPulse = !clrEn && (cnt_q == CNT_MAX);
      if (wrapPulse) begin
        ovf_d = 1'b1;
      end
    end
  end

  // Registers reset to zero and freeze while the enable is low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else if (clkEn) begin
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
    end
  end
  assign count = cnt_q;
  assign overflow = ovf_q;

  property p_cnt_clr;
    @(posedge clk) disable iff (!rst_n)
    clkEn && clrEn && !incEn |=> count == '0 && !overflow;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("counter not cleared");
  property p_cnt_wrap;
    @(posedge clk) disable iff (!rst_n)
    clkEn && incEn && !clrEn && count == CNT_MAX |=> overflow && count == '0;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) else $error("wrap lost overflow");
endmodule

// ===== tx_event_decode.sv
// Turns transmit status into one increment pulse per transmit counter.
module tx_event_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Transmit status
  input wire logic txDone,
  input wire logic txGood,
  input wire logic txBroadcast,
  input wire logic txMulticast,
  input wire logic txPause,
  input wire logic deferred_send_count,
  input wire logic txExcessive,
  input wire logic [stats_pkg::COLL_W-1:0] txCollNum,
  input wire logic txCollision,
  input wire logic [stats_pkg::BIT_W-1:0] collBitTime,
  input wire logic halfDuplex,
  // Increment pulses
  output logic [stats_pkg::TX_NUM-1:0] txInc
);
  import stats_pkg::*;
  logic sentOk; // Frame finished without error.

  // Broadcast addresses also look multicast, so broadcast wins.
  always_comb begin
    sentOk = txDone && txGood;
    txInc = '0;
    txInc[TXI_LATE] = txCollision && (collBitTime >= LATE_BIT_TIME);
    txInc[TXI_PAUSE] = sentOk && txPause;
    txInc[TXI_BCAST] = sentOk && txBroadcast;
    txInc[TXI_MCAST] = sentOk && txMulticast && !txBroadcast;
    txInc[TXI_UCAST] = sentOk && !txMulticast && !txBroadcast;
    txInc[TXI_DEFER] = txDone && deferred_send_count;
    txInc[TXI_TOTAL] = txCollision && halfDuplex;
    txInc[TXI_ABORT] = txDone && txExcessive;
    txInc[TXI_ONE] = sentOk && (txCollNum == COLL_ONE);
    txInc[TXI_MANY] = sentOk && (txCollNum > COLL_ONE);
  end

  property p_late;
    @(posedge clk) disable iff (!rst_n)
    txCollision && collBitTime < LATE_BIT_TIME |-> !txInc[TXI_LATE];
  endproperty
  a_late: assert property (p_late) else $error("early collision counted late");
  property p_full_dup;
    @(posedge clk) disable iff (!rst_n)
    !halfDuplex |-> !txInc[TXI_TOTAL];
  endproperty
  a_full_dup: assert property (p_full_dup) else $error("full duplex collision counted");
  property p_cast_excl;
    @(posedge clk) disable iff (!rst_n)
    !(txInc[TXI_BCAST] && txInc[TXI_MCAST]) && !(txInc[TXI_UCAST] && txInc[TXI_MCAST]);
  endproperty
  a_cast_excl: assert property (p_cast_excl) else $error("frame in two classes");
  property p_coll_excl;
    @(posedge clk) disable iff (!rst_n)
    !(txInc[TXI_ONE] && txInc[TXI_MANY]);
  endproperty
  a_coll_excl: assert property (p_coll_excl) else $error("one and many both");
endmodule

// ===== host_model.sv
// Host processor model: drives the register port and runs the counter fetch sequence.
module host_model (
  // Clock
  input wire logic clk,
  // Register port towards the counter bank
  output logic [stats_pkg::ADDR_W-1:0] regAddr,
  output logic [stats_pkg::DATA_W-1:0] regWrData,
  output logic regWr,
  output logic regRd,
  input wire logic [stats_pkg::DATA_W-1:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  import stats_pkg::*;

  // The port idles with both strobes low, so no stray access reaches the bank during reset.
  initial begin
    regAddr = '0;
    regWrData = '0;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // One-cycle write; every signal changes just after a rising edge.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // One-cycle read; the answer stands only in the following cycle, so it is taken mid-cycle.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    d = regRdData;
  endtask

  // Counter fetch: trigger, poll the high half until its valid bit is set, then the low half.
  // The poll is bounded, so a fetch that never completes returns a word with valid low.
  task automatic fetch(input logic [4:0] ofs, output logic [DATA_W-1:0] firstHi,
                       output logic [31:0] word);
    logic [DATA_W-1:0] hi;
    logic [DATA_W-1:0] lo;
    int n = 0;
    wr(REG_CTRL, 16'h1c00 | {11'h000, ofs});
    rd(REG_DATA_HI, hi);
    firstHi = hi;
    while (hi[14] !== 1'b1 && n < 20) begin
      rd(REG_DATA_HI, hi);
      n++;
    end
    rd(REG_DATA_LO, lo);
    word = {hi, lo};
  endtask
endmodule

// ===== tb_top.sv
// Self-checking bench for the statistics counter bank.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import stats_pkg::*;

  // Clock, reset and enable.
  logic clk;
  logic rst_n;
  logic clkEn;
  // Register port.
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData;
  logic regWr;
  logic regRd;
  logic [DATA_W-1:0] regRdData;
  // Transmit status, receive events and interrupt.
  logic txDone;
  logic txGood;
  logic txBroadcast;
  logic txMulticast;
  logic txPause;
  logic deferred_send_count;
  logic txExcessive;
  logic [COLL_W-1:0] txCollNum;
  logic txCollision;
  logic [BIT_W-1:0] collBitTime;
  logic halfDuplex;
  logic [RX_NUM-1:0] rxEvent;
  logic irq;
  // Bookkeeping.
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] hi;
  logic [31:0] w;
  // Expected counts at offsets 0x16 to 0x1F after the traffic below.
  int expCnt[10] = '{2, 1, 1, 1, 3, 1, 2, 1, 1, 1};

  mac_statistics_counters i_mac_statistics_counters (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData),
    .txDone(txDone), .txGood(txGood), .txBroadcast(txBroadcast),
    .txMulticast(txMulticast), .txPause(txPause), .deferred_send_count(deferred_send_count),
    .txExcessive(txExcessive), .txCollNum(txCollNum), .txCollision(txCollision),
    .collBitTime(collBitTime), .halfDuplex(halfDuplex), .rxEvent(rxEvent), .irq(irq)
  );

  host_model i_host_model (
    .clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData)
  );

  // Free-running 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // A hang is cut short well beyond the few hundred cycles the sequence needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  // Compares one value and reports a mismatch at once.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic end_of_test();
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One finished transmit; f is {good, broadcast, multicast, pause, deferred, excessive}.
  task automatic tx(input logic [5:0] f, input logic [COLL_W-1:0] cn);
    @(posedge clk);
    {txGood, txBroadcast, txMulticast, txPause, deferred_send_count, txExcessive} <= f;
    txCollNum <= cn;
    txDone <= 1'b1;
    @(posedge clk);
    txDone <= 1'b0;
  endtask

  // One collision at a given bit time, with the duplex level set alongside.
  task automatic coll(input logic [BIT_W-1:0] bt, input logic hd);
    @(posedge clk);
    collBitTime <= bt;
    halfDuplex <= hd;
    txCollision <= 1'b1;
    @(posedge clk);
    txCollision <= 1'b0;
  endtask

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    {txDone, txGood, txBroadcast, txMulticast, txPause, deferred_send_count, txExcessive} = '0;
    txCollNum = '0;
    txCollision = 1'b0;
    collBitTime = '0;
    halfDuplex = 1'b0;
    rxEvent = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, and a fetch whose first poll must still show the word as not valid.
    i_host_model.rd(REG_IRQ_MASK, d);
    check("mask after reset", {16'h0000, d}, 32'h0000_0000);
    i_host_model.fetch(5'h16, hi, w);
    check("first poll valid", {31'h0, hi[14]}, 32'h0000_0000);
    check("idle counter word", w, 32'h4000_0000);
    // One receive pulse, fetched with the literal trigger value.
    @(posedge clk);
    rxEvent <= 22'h004000;
    @(posedge clk);
    rxEvent <= '0;
    i_host_model.fetch(5'h0e, hi, w);
    check("rx counter word", w, 32'h4000_0001);
    i_host_model.rd(REG_CTRL, d);
    check("control readback", {16'h0000, d}, 32'h0000_0c0e);
    // Transmit traffic: broadcast that also looks multicast, good multicast, unicast after
    // one and three collisions, errored multicast, and a pause frame.
    tx(6'b111000, 5'h00);
    tx(6'b101000, 5'h00);
    tx(6'b100000, 5'h01);
    tx(6'b100000, 5'h03);
    tx(6'b001011, 5'h00);
    tx(6'b100100, 5'h00);
    // Collisions at the late boundary, one bit time before it, and a late one in full duplex.
    coll(16'h0200, 1'b1);
    coll(16'h01ff, 1'b1);
    coll(16'h0258, 1'b0);
    // Each counter holds its count once, and reads zero on the next fetch.
    // Every transmit counter is read back in turn, as the host must do regularly.
    for (int i = 0; i < 10; i++) begin
      i_host_model.fetch(5'(22 + i), hi, w);
      check("tx counter word", w, {2'b01, 30'(expCnt[i])});
      i_host_model.fetch(5'(22 + i), hi, w);
      check("tx counter cleared", w, 32'h4000_0000);
    end
    // Fetch-done interrupt: sticky status, masked, unmasked, cleared by writing one.
    i_host_model.rd(REG_IRQ_STAT, d);
    check("status after fetch", {16'h0000, d}, 32'h0000_0001);
    @(negedge clk);
    check("irq while masked", {31'h0, irq}, 32'h0000_0000);
    i_host_model.wr(REG_IRQ_MASK, 16'h0001);
    @(negedge clk);
    check("irq unmasked", {31'h0, irq}, 32'h0000_0001);
    i_host_model.wr(REG_IRQ_STAT, 16'h0001);
    @(negedge clk);
    check("irq after clear", {31'h0, irq}, 32'h0000_0000);
    // A trigger with the wrong table select is stored but starts no fetch.
    i_host_model.wr(REG_CTRL, 16'h100e);
    repeat (6) @(posedge clk);
    i_host_model.rd(REG_IRQ_STAT, d);
    check("no fetch on bad select", {16'h0000, d}, 32'h0000_0000);
    i_host_model.rd(REG_CTRL, d);
    check("bad select readback", {16'h0000, d}, 32'h0000_000e);
    // While the enable is low an event is lost; a later fetch raises the unmasked interrupt.
    @(posedge clk);
    clkEn <= 1'b0;
    rxEvent <= 22'h000004;
    @(posedge clk);
    rxEvent <= '0;
    clkEn <= 1'b1;
    i_host_model.fetch(5'h02, hi, w);
    check("event while frozen", w, 32'h4000_0000);
    @(negedge clk);
    check("irq on fetch", {31'h0, irq}, 32'h0000_0001);
    // Data registers are read only, so a write leaves the fetched word alone.
    i_host_model.wr(REG_DATA_HI, 16'hffff);
    i_host_model.rd(REG_DATA_HI, d);
    check("data high write refused", {16'h0000, d}, 32'h0000_4000);
    // A second reset in mid-run returns the mask to zero.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    i_host_model.rd(REG_IRQ_MASK, d);
    check("mask after second reset", {16'h0000, d}, 32'h0000_0000);
    // An unmapped address reads zero.
    i_host_model.rd(8'h0a, d);
    check("unmapped read", {16'h0000, d}, 32'h0000_0000);
    end_of_test();
  end
endmodule
